// File: core/fdc_pkg.sv
package fdc_pkg;
   localparam int NCH = 5;
   localparam int NTRIG = 31;
   localparam int CFG_BYTES = 8;
   localparam int FETCH_CLKS = CFG_BYTES + 1;
   // register byte offsets
   localparam logic [7:0] A_ARM = 8'h00;
   localparam logic [7:0] A_REQ = 8'h04;
   localparam logic [7:0] A_IST = 8'h08;
   localparam logic [7:0] A_IMSK = 8'h0C;
   localparam logic [7:0] A_PTR0 = 8'h10;
   localparam logic [7:0] A_STAT = 8'h24;
   localparam logic [4:0] RST_CH = 5'h00;
   localparam logic [15:0] RST_PTR = 16'h0000;
   // configuration byte positions
   localparam int CB_SRCH = 0;
   localparam int CB_SRCL = 1;
   localparam int CB_DSTH = 2;
   localparam int CB_DSTL = 3;
   localparam int CB_LENH = 4;
   localparam int CB_LENL = 5;
   localparam int CB_CTL = 6;
   localparam int CB_OPT = 7;
   localparam int VLEN_LSB = 5;
   localparam int TMODE_LSB = 5;
   localparam int WSIZE_BIT = 7;
   localparam int PRIO_LSB = 0;
   localparam int M8_BIT = 2;
   localparam int IMASK_BIT = 3;
   localparam int DINC_LSB = 4;
   localparam int SINC_LSB = 6;
   localparam logic [4:0] TRIG_NONE = 5'h1F;
   localparam int TM_BLK_BIT = 0;
   localparam int TM_REP_BIT = 1;
   localparam logic [1:0] PR_LOW = 2'h0;
   localparam logic [1:0] PR_ASSURED = 2'h1;
   localparam logic [1:0] PR_HIGH = 2'h2;
   localparam logic [2:0] VL_PLUS1 = 3'h1;
   localparam logic [2:0] VL_EXACT = 3'h2;
   localparam logic [2:0] VL_PLUS2 = 3'h3;
   localparam logic [2:0] VL_PLUS3 = 3'h4;
   typedef enum logic [4:0] {
      ST_IDLE = 5'h01, ST_FETCH = 5'h02, ST_RD = 5'h04, ST_CAP = 5'h08, ST_WR = 5'h10
   } fdc_state_e;
endpackage

// File: core/fdc_dma.sv
// What this block does
// RQ1 - five channels 0..4, each configured and armed on its own
// RQ2 - each transfer reads a source location then writes a destination
// RQ3 - addresses span the whole 16-bit external data space
// RQ4 - no transfer is accepted before the channel is armed
// RQ5 - an armed channel starts a transfer on its selected trigger
// RQ6 - configuration fetch takes 9 clocks; triggers meanwhile are lost
// RQ7 - chained fetches run in order 1,2,3,4,0; all go ready in the last 8 clocks
// RQ8 - trigger select, one of 31, comes from the fetched configuration
// RQ9 - software may force a transfer through the request register
// RQ10 - three priority levels arbitrate channels and CPU memory access
// RQ11 - single, block, repeated single and repeated block modes
// RQ12 - optional variable length taken from the first transferred unit
// RQ13 - byte or word units as the configuration selects
// RQ14 - eight-byte configuration is read from memory at the given pointer
// RQ15 - count end disarms or rearms the channel and notifies the CPU
// RQ16 - equal priority ties are settled round robin
// RQ17 - completion raises an interrupt unless the configuration masks it; irq also needs the channel's IMSK register bit set
// RQ18 - non-repeated completion clears the channel arm bit
`timescale 1ns/1ps
module fdc_dma #(
   parameter int N_CH = fdc_pkg::NCH
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic [fdc_pkg::NTRIG-1:0] trig_in,
   input wire logic cpu_req,
   output logic mem_en,
   output logic mem_we,
   output logic [15:0] mem_addr,
   output logic [7:0] mem_wdata,
   input wire logic [7:0] mem_rdata,
   output logic irq
);
   import fdc_pkg::*;

   if (N_CH != NCH)
   begin : g_chk
      $error("channel order logic serves exactly five channels");
   end

   fdc_state_e st;
   logic [4:0] arm, req, ist, imsk, ready, fpend, pend, fnext, staged;
   logic [15:0] ptr [NCH];
   logic [7:0] cfgb [NCH][CFG_BYTES];
   logic [15:0] sptr [NCH];
   logic [15:0] dptr [NCH];
   logic [12:0] cnt [NCH];
   logic [12:0] tot [NCH];
   logic [4:0] vfirst;
   logic [2:0] fch, cur, rr, lc;
   logic [3:0] fcnt;
   logic bi, turn, ok, fdone, wfin, cdone, ld;
   logic [7:0] dbuf0, dbuf1;
   logic [12:0] vtot, teff;
   logic ap_wr;
   logic [7:0] ap_addr;
   logic wr_arm, wr_req, wr_ist;

   ////////////////////////////////////////////////////////////////
   // configuration field decode
   function automatic logic [1:0] f_prio(input logic [2:0] c);
      return cfgb[c][CB_OPT][PRIO_LSB+:2];
   endfunction
   function automatic logic f_rep(input logic [2:0] c);
      return cfgb[c][CB_CTL][TMODE_LSB+TM_REP_BIT];
   endfunction
   function automatic logic f_blk(input logic [2:0] c);
      return cfgb[c][CB_CTL][TMODE_LSB+TM_BLK_BIT];
   endfunction
   function automatic logic f_word(input logic [2:0] c);
      return cfgb[c][CB_CTL][WSIZE_BIT];
   endfunction
   function automatic logic [12:0] f_len(input logic [2:0] c);
      return {cfgb[c][CB_LENH][4:0], cfgb[c][CB_LENL]};
   endfunction
   function automatic logic [2:0] f_vlen(input logic [2:0] c);
      return cfgb[c][CB_LENH][VLEN_LSB+:3];
   endfunction
   // RQ8 trigger from config
   function automatic logic f_hit(input logic [2:0] c);
      logic [4:0] t;
      t = cfgb[c][CB_CTL][4:0];
      return (t != TRIG_NONE) && trig_in[t];
   endfunction
   // increment codes: none, +1, +2, -1
   function automatic logic [15:0] f_step(input logic [15:0] a, input logic [1:0] inc);
      unique case (inc)
         2'h0: return a;
         2'h1: return a + 16'h0001;
         2'h2: return a + 16'h0002;
         2'h3: return a - 16'h0001;
      endcase
   endfunction
   // RQ7 fetch order
   function automatic logic [2:0] f_fpick(input logic [4:0] p);
      logic [2:0] s;
      s = 3'h0;
      for (int i = NCH - 1; i >= 1; i--)
         if (p[i])
            s = 3'(i);
      return s;
   endfunction
   // RQ16 round robin tie
   function automatic logic [2:0] f_tpick(input logic [4:0] p, input logic [2:0] r);
      logic [2:0] s, c;
      logic [1:0] best;
      logic fnd;
      s = r;
      best = PR_LOW;
      fnd = 1'b0;
      for (int k = 1; k <= NCH; k++)
      begin
         c = 3'((int'(r) + k) % NCH);
         if (p[c] && (!fnd || f_prio(c) > best))
         begin
            fnd = 1'b1;
            best = f_prio(c);
            s = c;
         end
      end
      return s;
   endfunction

   ////////////////////////////////////////////////////////////////
   // RQ10 cpu arbitration
   // assured level alternates with a busy cpu, low level only uses idle cycles
   // a process rather than an assign, so it also wakes on configuration bytes read in functions
   always_comb
   begin
      ok = f_prio(cur) >= PR_HIGH || !cpu_req || (f_prio(cur) == PR_ASSURED && turn);
      wfin = st == ST_WR && ok && (!f_word(cur) || bi);
   end
   // RQ6 nine clock fetch
   assign fdone = st == ST_FETCH && fcnt == 4'(FETCH_CLKS - 1);
   assign fnext = fpend & ~(5'h01 << fch);
   assign teff = vfirst[cur] ? vtot : tot[cur];
   assign cdone = wfin && ({1'b0, cnt[cur]} + 14'h0001) >= {1'b0, teff};
   always_comb
      ld = fdone || (cdone && f_rep(cur));
   assign lc = fdone ? fch : cur;

   // RQ12 variable length from first unit, capped at length field
   always_comb
   begin
      logic [13:0] fv, n;
      fv = f_word(cur) ? {1'b0, dbuf1[4:0], dbuf0}
         : {6'h00, cfgb[cur][CB_OPT][M8_BIT] & dbuf0[7], dbuf0[6:0]};
      unique case (f_vlen(cur))
         VL_PLUS1: n = fv + 14'h0001;
         VL_EXACT: n = fv;
         VL_PLUS2: n = fv + 14'h0002;
         VL_PLUS3: n = fv + 14'h0003;
         default: n = {1'b0, f_len(cur)};
      endcase
      vtot = (n > {1'b0, f_len(cur)}) ? f_len(cur) : n[12:0];
   end

   // RQ3 full 16-bit address
   assign mem_en = (st == ST_FETCH && fcnt < 4'(CFG_BYTES)) || ((st == ST_RD || st == ST_WR) && ok);
   assign mem_we = st == ST_WR && ok;
   assign mem_wdata = bi ? dbuf1 : dbuf0;
   always_comb
   begin
      // RQ14 structure read at pointer
      if (st == ST_FETCH)
         mem_addr = ptr[fch] + {12'h000, fcnt};
      else if (st == ST_RD)
         mem_addr = sptr[cur] + {15'h0000, bi};
      else
         mem_addr = dptr[cur] + {15'h0000, bi};
   end

   ////////////////////////////////////////////////////////////////
   // transfer engine, one unit at a time so channels re-arbitrate between units
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
      begin
         st <= ST_IDLE;
         fch <= 3'h0;
         fcnt <= 4'h0;
         cur <= 3'h0;
         bi <= 1'b0;
         turn <= 1'b0;
         rr <= 3'h0;
         dbuf0 <= 8'h00;
         dbuf1 <= 8'h00;
      end
      else
      begin
         if ((st == ST_RD || st == ST_WR) && cpu_req && f_prio(cur) == PR_ASSURED)
            turn <= ~turn;
         unique case (st)
            ST_IDLE:
               if (fpend != 5'h00)
               begin
                  fch <= f_fpick(fpend);
                  fcnt <= 4'h0;
                  st <= ST_FETCH;
               end
               // RQ5 start on pending trigger
               else if (pend != 5'h00)
               begin
                  cur <= f_tpick(pend, rr);
                  bi <= 1'b0;
                  st <= ST_RD;
               end
            ST_FETCH:
               // RQ7 chain fetches without gaps
               if (fdone && fnext != 5'h00)
               begin
                  fch <= f_fpick(fnext);
                  fcnt <= 4'h0;
               end
               else if (fdone)
                  st <= ST_IDLE;
               else
                  fcnt <= fcnt + 4'h1;
            // RQ2 read source
            ST_RD:
               if (ok)
                  st <= ST_CAP;
            ST_CAP:
            begin
               if (bi)
                  dbuf1 <= mem_rdata;
               else
                  dbuf0 <= mem_rdata;
               // RQ13 word takes two bytes
               if (f_word(cur) && !bi)
                  st <= ST_RD;
               else
                  st <= ST_WR;
               bi <= f_word(cur) && !bi;
            end
            // RQ2 write destination
            ST_WR:
               if (ok && f_word(cur) && !bi)
                  bi <= 1'b1;
               else if (ok)
               begin
                  bi <= 1'b0;
                  rr <= cur;
                  st <= ST_IDLE;
               end
         endcase
      end

   // configuration capture, one byte per clock behind the read
   always_ff @(posedge hclk)
      if (st == ST_FETCH && fcnt != 4'h0)
         cfgb[fch][3'(fcnt - 4'h1)] <= mem_rdata;

   // RQ15 reload pointers on fetch or repeated completion
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
      begin
         for (int c = 0; c < NCH; c++)
         begin
            sptr[c] <= RST_PTR;
            dptr[c] <= RST_PTR;
            cnt[c] <= 13'h0000;
            tot[c] <= 13'h0000;
         end
         vfirst <= RST_CH;
      end
      else if (ld)
      begin
         sptr[lc] <= {cfgb[lc][CB_SRCH], cfgb[lc][CB_SRCL]};
         dptr[lc] <= {cfgb[lc][CB_DSTH], cfgb[lc][CB_DSTL]};
         cnt[lc] <= 13'h0000;
         tot[lc] <= f_len(lc);
         vfirst[lc] <= f_vlen(lc) != 3'h0;
      end
      else if (wfin)
      begin
         sptr[cur] <= f_step(sptr[cur], cfgb[cur][CB_OPT][SINC_LSB+:2]);
         dptr[cur] <= f_step(dptr[cur], cfgb[cur][CB_OPT][DINC_LSB+:2]);
         cnt[cur] <= cnt[cur] + 13'h0001;
         tot[cur] <= teff;
         vfirst[cur] <= 1'b0;
      end

   ////////////////////////////////////////////////////////////////
   // RQ1 per-channel arm, fetch, ready and pending state
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
      begin
         arm <= RST_CH;
         req <= RST_CH;
         ready <= RST_CH;
         fpend <= RST_CH;
         pend <= RST_CH;
         staged <= RST_CH;
      end
      else
         for (int c = 0; c < NCH; c++)
         begin
            // RQ7 chained fetch holds its channel back until the last fetch of the chain
            if (fdone && fch == 3'(c))
            begin
               fpend[c] <= 1'b0;
               if (fnext != 5'h00)
                  staged[c] <= 1'b1;
               else
                  ready[c] <= 1'b1;
            end
            // RQ7 held channels go ready one a clock, fetch order, inside the last fetch
            if (staged[c] && st == ST_FETCH && fnext == 5'h00
               && (fdone || (fcnt != 4'h0 && f_fpick(staged) == 3'(c))))
            begin
               staged[c] <= 1'b0;
               ready[c] <= 1'b1;
            end
            // RQ18 disarm on completion
            if (cdone && cur == 3'(c) && !f_rep(cur))
            begin
               arm[c] <= 1'b0;
               ready[c] <= 1'b0;
            end
            if (wr_arm && hwdata[c])
            begin
               arm[c] <= 1'b1;
               fpend[c] <= 1'b1;
               ready[c] <= 1'b0;
               staged[c] <= 1'b0;
            end
            // RQ9 forced request, RQ4 armed only
            if (wr_req && hwdata[c] && arm[c])
               req[c] <= 1'b1;
            else if (ready[c])
               req[c] <= 1'b0;
            // RQ11 single clears per unit, block at count end
            if (cur == 3'(c) && (cdone || (wfin && !f_blk(cur))))
               pend[c] <= 1'b0;
            // RQ6 only a ready channel takes a trigger
            if (ready[c] && (req[c] || f_hit(3'(c))))
               pend[c] <= 1'b1;
         end

   ////////////////////////////////////////////////////////////////
   // zero wait AHB-Lite slave, read data registered in the address phase
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign wr_arm = ap_wr && ap_addr == A_ARM;
   assign wr_req = ap_wr && ap_addr == A_REQ;
   assign wr_ist = ap_wr && ap_addr == A_IST;

   function automatic logic [31:0] f_rd(input logic [7:0] a);
      logic [31:0] v;
      v = 32'h0000_0000;
      if (a == A_ARM) v = {27'h0000000, arm};
      if (a == A_REQ) v = {27'h0000000, req};
      if (a == A_IST) v = {27'h0000000, ist};
      if (a == A_IMSK) v = {27'h0000000, imsk};
      if (a == A_STAT) v = {17'h00000, pend, fpend, ready};
      for (int c = 0; c < NCH; c++)
         if (a == A_PTR0 + 8'(4 * c))
            v = {16'h0000, ptr[c]};
      return v;
   endfunction

   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
      begin
         ap_wr <= 1'b0;
         ap_addr <= 8'h00;
         hrdata <= 32'h0000_0000;
         imsk <= RST_CH;
         for (int c = 0; c < NCH; c++)
            ptr[c] <= RST_PTR;
      end
      else
      begin
         if (ap_wr && ap_addr == A_IMSK)
            imsk <= hwdata[4:0];
         for (int c = 0; c < NCH; c++)
            if (ap_wr && ap_addr == A_PTR0 + 8'(4 * c))
               ptr[c] <= hwdata[15:0];
         ap_wr <= 1'b0;
         if (hsel && hready && htrans[1] && hsize == 3'h2)
         begin
            ap_wr <= hwrite && haddr[31:8] == 24'h000000;
            ap_addr <= haddr[7:0];
            hrdata <= (hwrite || haddr[31:8] != 24'h000000) ? 32'h0000_0000 : f_rd(haddr[7:0]);
         end
      end

   // RQ17 sticky completion flags, write one to clear, a new event wins
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
         ist <= RST_CH;
      else
         for (int c = 0; c < NCH; c++)
            if (cdone && cur == 3'(c) && !cfgb[cur][CB_OPT][IMASK_BIT])
               ist[c] <= 1'b1;
            else if (wr_ist && hwdata[c])
               ist[c] <= 1'b0;

   assign irq = |(ist & imsk);

   ////////////////////////////////////////////////////////////////
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   sequence s_fetch;
      (st == ST_FETCH)[*8] ##1 fdone;
   endsequence
   property p_fetch9;
      (st == ST_IDLE && fpend != 5'h00) |=> s_fetch;
   endproperty
   a_fetch9: assert property (p_fetch9) else $error("fetch not nine clocks"); // RQ6
   property p_ignore;
      (pend & ~$past(pend) & ~$past(ready)) == 5'h00;
   endproperty
   a_ignore: assert property (p_ignore) else $error("pending without ready"); // RQ4
   property p_chain;
      (fdone && fnext != 5'h00) |=> st == ST_FETCH && fcnt == 4'h0;
   endproperty
   a_chain: assert property (p_chain) else $error("fetch chain gap"); // RQ7
   property p_disarm;
      (cdone && !f_rep(cur)) |=> !arm[$past(cur)] && !ready[$past(cur)];
   endproperty
   a_disarm: assert property (p_disarm) else $error("channel not disarmed"); // RQ18
   property p_release;
      (st == ST_IDLE) |-> staged == 5'h00;
   endproperty
   a_release: assert property (p_release) else $error("held channel never went ready"); // RQ7
   property p_irq;
      (cdone && !cfgb[cur][CB_OPT][IMASK_BIT]) |=> ist[$past(cur)];
   endproperty
   a_irq: assert property (p_irq) else $error("completion flag missing"); // RQ17
   property p_low;
      (st == ST_RD && cpu_req && f_prio(cur) == PR_LOW) |-> !mem_en;
   endproperty
   a_low: assert property (p_low) else $error("low priority beat cpu"); // RQ10
   property p_start;
      (st == ST_IDLE && fpend == 5'h00 && pend != 5'h00) |=> st == ST_RD && pend[cur];
   endproperty
   a_start: assert property (p_start) else $error("pending channel not started"); // RQ5
   sequence s_second;
      st == ST_RD && bi ##1 st == ST_CAP;
   endsequence
   property p_word;
      (st == ST_CAP && f_word(cur) && !bi && f_prio(cur) >= PR_HIGH) |=> s_second;
   endproperty
   a_word: assert property (p_word) else $error("word lacks second byte"); // RQ13
endmodule

// File: tb/fdc_mem_model.sv
`timescale 1ns/1ps
module fdc_mem_model (
   input wire logic hclk,
   input wire logic mem_en,
   input wire logic mem_we,
   input wire logic [15:0] mem_addr,
   input wire logic [7:0] mem_wdata,
   output logic [7:0] mem_rdata
);
   // whole 16-bit space so any source or destination the bench picks exists
   logic [7:0] mem [0:65535];

   initial mem_rdata = 8'h00;

   ////////////////////////////////////////////////////////////////////////////////
   // synchronous read port
   // data one cycle after the read; otherwise the inverse, so stale bytes never match
   always @(posedge hclk)
   begin
      if (mem_en === 1'b1 && mem_we === 1'b0)
         mem_rdata <= mem[mem_addr];
      else
         mem_rdata <= ~mem_rdata;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // destination write port
   always @(posedge hclk)
   begin
      if (mem_en === 1'b1 && mem_we === 1'b1)
         mem[mem_addr] <= mem_wdata;
   end
endmodule

// File: tb/five_channel_dma_controller_tb.sv
`timescale 1ns/1ps
module five_channel_dma_controller_tb;
   import fdc_pkg::*;
   typedef struct {int ch; int tm; int wd; int vl; int len; int first; int pr; int cr; int reps;
      int nb;} fdc_row_s;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, cpu_req, mem_en, mem_we, irq;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [30:0] trig_in;
   logic [15:0] mem_addr;
   logic [7:0] mem_wdata, mem_rdata;
   int n_errors = 0;
   int n_compared = 0;
   int n_mem = 0;
   int cyc = 0;
   // ch tm wd vl len first pr cr reps nb; repeated rows last since they stay armed
   fdc_row_s rows [10] = '{'{0, 0, 0, 0, 3, 0, 0, 0, 3, 3}, '{1, 1, 0, 0, 4, 0, 0, 0, 1, 4},
      '{4, 1, 0, 1, 8, 2, 0, 0, 1, 3}, '{0, 1, 0, 2, 8, 3, 0, 0, 1, 3},
      '{1, 1, 0, 3, 8, 1, 0, 0, 1, 3}, '{4, 1, 0, 4, 8, 0, 0, 0, 1, 3},
      '{0, 1, 0, 1, 4, 9, 0, 0, 1, 4}, '{1, 1, 1, 0, 1, 0, 2, 1, 1, 2},
      '{2, 3, 0, 0, 2, 0, 0, 0, 1, 2}, '{3, 2, 0, 0, 2, 0, 0, 0, 2, 2}};

   initial hclk = 1'b0;
   always #5 hclk = ~hclk;

   // cycle count and memory access count for timing and hold-off checks
   always @(posedge hclk)
   begin
      cyc <= cyc + 1;
      if (mem_en === 1'b1)
         n_mem <= n_mem + 1;
   end

   fdc_dma #(.N_CH(NCH)) dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .trig_in(trig_in),
      .cpu_req(cpu_req), .mem_en(mem_en), .mem_we(mem_we), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .irq(irq));

   fdc_mem_model mem_u (.hclk(hclk), .mem_en(mem_en), .mem_we(mem_we), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic results();
      $display("compared %0d errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e)
      begin
         n_errors++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask

   // one single ahb transfer; waits on hready rather than assuming zero wait states
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h000000, a};
      hwrite <= wr;
      hsize <= 3'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      bus(1'b0, a, 32'h00000000, q);
   endtask

   // bounded poll of a register field
   task automatic wait_reg(input string nm, input logic [7:0] a, input logic [31:0] m,
      input logic [31:0] v);
      logic [31:0] q;
      int k;
      k = 0;
      rd(a, q);
      while ((q & m) !== v && k < 300)
      begin
         rd(a, q);
         k++;
      end
      chk(nm, v, q & m);
   endtask

   // config block at 0x0100 + 8*i, pointer written to the channel
   task automatic cfg(input int i, input int ch, input logic [15:0] s, input logic [15:0] d,
      input logic [7:0] b4, input logic [7:0] b5, input logic [7:0] b6, input logic [7:0] b7);
      logic [63:0] w;
      logic [15:0] p;
      int k;
      p = 16'h0100 + 16'(i * 8);
      w = {s, d, b4, b5, b6, b7};
      for (k = 0; k < 8; k++)
         mem_u.mem[p + 16'(k)] = w[63 - 8 * k -: 8];
      wr(A_PTR0 + 8'(4 * ch), {16'h0000, p});
   endtask

   task automatic fill(input logic [15:0] s, input logic [15:0] d);
      int k;
      for (k = 0; k < 16; k++)
      begin
         mem_u.mem[s + 16'(k)] = 8'h40 + 8'(k);
         mem_u.mem[d + 16'(k)] = 8'hEE;
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      fdc_row_s r;
      logic [31:0] q, m;
      logic [15:0] s, d;
      logic [4:0] seen, nw;
      logic [19:0] ord;
      int i, j, k, t0, t1, nm, tf;
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h00000000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h0;
      hwdata = 32'h00000000;
      trig_in = 31'h00000000;
      cpu_req = 1'b0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      // reset values and an unmapped offset
      rd(A_ARM, q);
      chk("arm after reset", 32'h0, q);
      rd(A_STAT, q);
      chk("stat after reset", 32'h0, q);
      rd(8'h40, q);
      chk("unmapped read", 32'h0, q);
      chk("hresp okay", 32'h0, hresp);
      chk("irq after reset", 32'h0, irq);
      // arm all five at once, watch the order channels become ready
      for (i = 0; i < 5; i++)
      begin
         mem_u.mem[16'h3000 + 16'(i)] = 8'hA0 + 8'(i);
         mem_u.mem[16'h3100 + 16'(i)] = 8'hEE;
         cfg(10 + i, i, 16'h3000 + 16'(i), 16'h3100 + 16'(i), 8'h00, 8'h01,
            {1'b0, 2'd1, TRIG_NONE}, 8'h54);
      end
      wr(A_ARM, 32'h1F);
      t0 = cyc;
      seen = 5'h00;
      ord = 20'h00000;
      k = 0;
      while (seen != 5'h1F && k < 60)
      begin
         rd(A_STAT, q);
         nw = q[4:0] & ~seen;
         if (seen == 5'h00 && nw != 5'h00)
            tf = cyc;
         for (j = 0; j < 5; j++)
            if (nw[j])
               ord = {ord[15:0], 4'(j)};
         seen = seen | nw;
         k++;
      end
      t1 = cyc;
      chk("ready order", 32'h00012340, {12'h000, ord});
      chk("fetch span in range", 32'h1, 32'(t1 - t0 >= 44 && t1 - t0 <= 52));
      // first and last ready seen within the last 8 clocks plus polling slack
      chk("ready window", 32'h1, 32'(t1 - tf <= 10));
      wr(A_REQ, 32'h1F);
      wait_reg("all channels done", A_IST, 32'h1F, 32'h1F);
      chk("irq masked", 32'h0, irq);
      for (i = 0; i < 5; i++)
         chk("dst byte", 8'hA0 + 8'(i), mem_u.mem[16'h3100 + 16'(i)]);
      wr(A_IST, 32'h1F);
      rd(A_ARM, q);
      chk("arm cleared", 32'h0, q);
      // table of modes, sizes and length options
      for (i = 0; i < 10; i++)
      begin
         r = rows[i];
         m = 32'h1 << r.ch;
         s = 16'h1000 + 16'(i * 32);
         d = 16'h2000 + 16'(i * 32);
         fill(s, d);
         if (r.vl != 0)
            mem_u.mem[s] = 8'(r.first);
         cfg(i, r.ch, s, d, {3'(r.vl), 5'h00}, 8'(r.len), {r.wd[0], 2'(r.tm), TRIG_NONE},
            {6'b010101, 2'(r.pr)});
         wr(A_IMSK, m);
         cpu_req <= r.cr[0];
         wr(A_ARM, m);
         wait_reg("channel ready", A_STAT, m, m);
         for (k = 0; k < r.reps; k++)
         begin
            wr(A_REQ, m);
            wait_reg("request taken", A_REQ, m, 32'h0);
            wait_reg("transfer idle", A_STAT, m << 10, 32'h0);
         end
         wait_reg("done flag", A_IST, m, m);
         cpu_req <= 1'b0;
         chk("irq raised", 32'h1, irq);
         for (k = 0; k < 16; k++)
            chk("dst byte", k < r.nb ? mem_u.mem[s + 16'(k)] : 8'hEE,
               mem_u.mem[d + 16'(k)]);
         rd(A_ARM, q);
         chk("arm after count", r.tm >= 2 ? m : 32'h0, q & m);
         wr(A_IST, m);
         @(negedge hclk);
         chk("irq cleared", 32'h0, irq);
      end
      // hardware trigger: ignored unarmed and during fetch, taken once ready
      fill(16'h1400, 16'h2400);
      cfg(12, 4, 16'h1400, 16'h2400, 8'h00, 8'h01, {1'b0, 2'd0, 5'd5}, 8'h54);
      wr(A_IMSK, 32'h10);
      nm = n_mem;
      trig_in[5] <= 1'b1;
      repeat (3) @(posedge hclk);
      trig_in[5] <= 1'b0;
      repeat (3) @(posedge hclk);
      chk("no access unarmed", nm, n_mem);
      wr(A_ARM, 32'h10);
      trig_in[5] <= 1'b1;
      repeat (4) @(posedge hclk);
      trig_in[5] <= 1'b0;
      wait_reg("trigger channel ready", A_STAT, 32'h10, 32'h10);
      repeat (4) @(posedge hclk);
      rd(A_IST, q);
      chk("trigger in fetch lost", 32'h0, q & 32'h10);
      trig_in[5] <= 1'b1;
      @(posedge hclk);
      trig_in[5] <= 1'b0;
      wait_reg("trigger done", A_IST, 32'h10, 32'h10);
      chk("triggered byte", 8'h40, mem_u.mem[16'h2400]);
      wr(A_IST, 32'h10);
      // low priority waits while the cpu holds memory
      fill(16'h1500, 16'h2500);
      cfg(13, 0, 16'h1500, 16'h2500, 8'h00, 8'h02, {1'b0, 2'd1, TRIG_NONE}, 8'h54);
      wr(A_ARM, 32'h01);
      wait_reg("low prio ready", A_STAT, 32'h01, 32'h01);
      cpu_req <= 1'b1;
      wr(A_REQ, 32'h01);
      nm = n_mem;
      repeat (20) @(posedge hclk);
      chk("low prio held off", nm, n_mem);
      cpu_req <= 1'b0;
      wait_reg("low prio done", A_IST, 32'h01, 32'h01);
      for (k = 0; k < 2; k++)
         chk("low prio byte", 8'h40 + 8'(k), mem_u.mem[16'h2500 + 16'(k)]);
      results();
   end

   // watchdog far beyond the several hundred cycles the sequence needs
   initial
   begin
      #400000;
      n_errors++;
      results();
   end
endmodule
